// ===== logic/mdc_pkg.sv
// Purpose: shared constants for the motor driver control register bank
// Assumes: 8-bit registers, 6-bit register address from the frame decoder
// Notes: offsets, field positions, keys and reset values are defined here; the register bank and bench also repeat some as literals
package mdc_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [5:0] OFS_CONTROL_LOCK = 6'h03;
   localparam logic [5:0] OFS_DRIVE_CONFIGURATION = 6'h04;
   localparam logic [5:0] OFS_PROTECTION_REPORTING = 6'h05;

   // reset values
   localparam logic [7:0] RST_CONTROL_LOCK = 8'h00;
   localparam logic [7:0] RST_DRIVE_CONFIGURATION = 8'h60;
   localparam logic [7:0] RST_PROTECTION_REPORTING = 8'h46;

   // control_lock fields
   localparam int LOCK_LSB = 0;
   localparam int LOCK_W = 3;
   localparam logic [2:0] LOCK_KEY_UNLOCK = 3'h3;
   localparam logic [2:0] LOCK_KEY_LOCK = 3'h6;

   // drive_configuration fields
   localparam int DRV_RSVD_LSB = 6;
   localparam int DRV_SDO_BIT = 5;
   localparam int DRV_SLEW_LSB = 3;
   localparam int DRV_SCHEME_LSB = 1;
   localparam int DRV_CLEAR_BIT = 0;

   // protection_reporting fields
   localparam int PRT_RSVD_BIT = 7;
   localparam int PRT_RSVD_HI_BIT = 6;
   localparam int PRT_RSVD_LO_BIT = 5;
   localparam int PRT_DUTY_RATE_BIT = 4;
   localparam int PRT_OV_SEL_BIT = 3;
   localparam int PRT_OV_ON_BIT = 2;
   localparam int PRT_SER_OFF_BIT = 1;
   localparam int PRT_OTW_ON_BIT = 0;

   // slew codes, V/us: 25, 50, 125, 200
   localparam logic [1:0] SLEW_25 = 2'h0;
   localparam logic [1:0] SLEW_50 = 2'h1;
   localparam logic [1:0] SLEW_125 = 2'h2;
   localparam logic [1:0] SLEW_200 = 2'h3;

   typedef enum logic [1:0] {
      MDC_SCHEME_SIX,
      MDC_SCHEME_SIX_ILIM,
      MDC_SCHEME_THREE,
      MDC_SCHEME_THREE_ILIM
   } mdc_scheme_e;

   localparam int SYNC_STAGES = 3;
endpackage

// ===== logic/mdc_sync3.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs asynchronous to clk_sys_i
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ns
module mdc_sync3 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // pins in, filtered level out
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         stage1_reg <= RESET_VAL;
         stage2_reg <= RESET_VAL;
         stage3_reg <= RESET_VAL;
      end else begin
         stage1_reg <= async_i;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // stage one feeds stage two only, never the filter
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         always_ff @(posedge clk_sys_i) begin
            if (reset_i) begin
               level_o[gi] <= RESET_VAL[gi];
            end else if (stage2_reg[gi] == stage3_reg[gi]) begin
               level_o[gi] <= stage3_reg[gi];
            end
         end
      end
   endgenerate
endmodule // mdc_sync3

// ===== logic/mdc_fault_report.sv
// Purpose: drives the open-drain fault indicator pin from fault sources
// Assumes: all inputs already in the clk_sys_i domain
// Notes: pin is pulled low while oe is high; released otherwise
`timescale 1ns/1ns
module mdc_fault_report (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // fault sources
   input wire logic driver_fault_i,
   input wire logic overtemp_warning_i,
   input wire logic serial_fault_any_i,
   // reporting controls
   input wire logic serial_fault_report_off_i,
   input wire logic overtemp_warning_report_on_i,
   // open-drain pin
   output logic fault_indicator_pin_o,
   output logic fault_indicator_pin_oe_o
);
   logic assert_next;

   always_comb begin
      assert_next = driver_fault_i;
      if (serial_fault_any_i && !serial_fault_report_off_i) begin
         assert_next = 1'b1;
      end
      if (overtemp_warning_i && overtemp_warning_report_on_i) begin
         assert_next = 1'b1;
      end
   end

   assign fault_indicator_pin_o = 1'b0;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         fault_indicator_pin_oe_o <= 1'b0;
      end else begin
         fault_indicator_pin_oe_o <= assert_next;
      end
   end
endmodule // mdc_fault_report

// ===== logic/mdc_control_regs.sv
// Purpose: lock, drive configuration and protection registers of the
//    motor driver, written by the serial frame decoder
// Assumes: each decoded write arrives as one atomic strobe with full data
// Notes: reads return registered data one cycle after the read strobe
`timescale 1ns/1ns
module mdc_control_regs #(
   parameter int ADDR_W = mdc_pkg::ADDR_W
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // register access from the serial frame decoder
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // serial interface fault events from the frame decoder
   input wire logic serial_clock_framing_event_i,
   input wire logic serial_parity_event_i,
   input wire logic serial_address_event_i,
   // asynchronous fault levels from the power stage
   input wire logic driver_fault_i,
   input wire logic overtemp_warning_i,
   // configuration outputs
   output logic serial_out_drive_select_o,
   output logic [1:0] slew_select_o,
   output logic [1:0] input_scheme_o,
   output logic full_duty_rate_40k_o,
   output logic overvoltage_threshold_select_o,
   output logic overvoltage_protect_on_o,
   output logic registers_locked_o,
   output logic latched_fault_clear_o,
   // latched serial fault status
   output logic serial_clock_framing_flag_o,
   output logic serial_parity_flag_o,
   output logic serial_address_flag_o,
   // open-drain fault indicator pin
   output logic fault_indicator_pin_o,
   output logic fault_indicator_pin_oe_o
);
   localparam logic [ADDR_W-1:0] A_LOCK =
      ADDR_W'(mdc_pkg::OFS_CONTROL_LOCK);
   localparam logic [ADDR_W-1:0] A_DRIVE =
      ADDR_W'(mdc_pkg::OFS_DRIVE_CONFIGURATION);
   localparam logic [ADDR_W-1:0] A_PROT =
      ADDR_W'(mdc_pkg::OFS_PROTECTION_REPORTING);
   localparam logic [7:0] DRV_RST = mdc_pkg::RST_DRIVE_CONFIGURATION;
   localparam logic [7:0] PRT_RST = mdc_pkg::RST_PROTECTION_REPORTING;
   localparam logic [7:0] LCK_RST = mdc_pkg::RST_CONTROL_LOCK;

   // write decode
   logic wr_lock;
   logic wr_drive;
   logic wr_prot;

   // stored state
   logic [2:0] lock_field_reg;
   logic locked_reg;
   logic [1:0] drive_rsvd_reg;
   logic sdo_push_pull_reg;
   logic [1:0] slew_reg;
   mdc_pkg::mdc_scheme_e scheme_reg;
   logic clear_pulse_reg;
   logic [6:0] prot_reg;
   logic framing_flag_reg;
   logic parity_flag_reg;
   logic address_flag_reg;
   logic [7:0] rdata_next;

   // next values, held unless their write (a read for reg_rdata_next) is taken; clear_next and reg_rvalid_next only pulse
   logic [2:0] lock_field_next;
   logic locked_next;
   logic [1:0] drive_rsvd_next;
   logic sdo_push_pull_next;
   logic [1:0] slew_next;
   mdc_pkg::mdc_scheme_e scheme_next;
   logic clear_next;
   logic [6:0] prot_next;
   logic [7:0] reg_rdata_next;
   logic reg_rvalid_next;

   // synchronised pin levels
   logic [1:0] pin_level;

   // locked writes to drive and protection are dropped at the decode, so nothing else sees them; lock offset writes still pass
   always_comb begin
      wr_lock = 1'b0;
      wr_drive = 1'b0;
      wr_prot = 1'b0;
      if (!reg_wr_i) begin
         wr_lock = 1'b0;
      end else if (reg_addr_i == A_LOCK) begin
         wr_lock = 1'b1;
      end else if (reg_addr_i == A_DRIVE) begin
         wr_drive = !locked_reg;
      end else if (reg_addr_i == A_PROT) begin
         wr_prot = !locked_reg;
      end
   end

   // lock field holds the last atomic write, whatever the key
   always_comb begin
      lock_field_next = lock_field_reg;
      if (wr_lock) begin
         lock_field_next = reg_wdata_i[mdc_pkg::LOCK_W-1:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         lock_field_reg <= LCK_RST[mdc_pkg::LOCK_W-1:0];
      end else begin
         lock_field_reg <= lock_field_next;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         locked_reg <= 1'b0;
      end else begin
         locked_reg <= locked_next;
      end
   end

   // keys act only on a write to the lock offset
   always_comb begin
      locked_next = locked_reg;
      if (wr_lock) begin
         if (reg_wdata_i[2:0] == mdc_pkg::LOCK_KEY_LOCK) begin
            locked_next = 1'b1;
         end else if (reg_wdata_i[2:0] == mdc_pkg::LOCK_KEY_UNLOCK) begin
            locked_next = 1'b0;
         end
         // any other value leaves the state as it was
      end
   end

   // drive fields load whole on a taken write
   always_comb begin
      drive_rsvd_next = drive_rsvd_reg;
      sdo_push_pull_next = sdo_push_pull_reg;
      slew_next = slew_reg;
      scheme_next = scheme_reg;
      if (wr_drive) begin
         drive_rsvd_next = reg_wdata_i[mdc_pkg::DRV_RSVD_LSB +: 2];
         sdo_push_pull_next = reg_wdata_i[mdc_pkg::DRV_SDO_BIT];
         slew_next = reg_wdata_i[mdc_pkg::DRV_SLEW_LSB +: 2];
         scheme_next = mdc_pkg::mdc_scheme_e'(
            reg_wdata_i[mdc_pkg::DRV_SCHEME_LSB +: 2]);
      end
   end

   // drive configuration fields
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         drive_rsvd_reg <= DRV_RST[7:6];
         sdo_push_pull_reg <= DRV_RST[mdc_pkg::DRV_SDO_BIT];
         slew_reg <= DRV_RST[4:3];
         scheme_reg <= mdc_pkg::mdc_scheme_e'(DRV_RST[2:1]);
      end else begin
         drive_rsvd_reg <= drive_rsvd_next;
         sdo_push_pull_reg <= sdo_push_pull_next;
         slew_reg <= slew_next;
         scheme_reg <= scheme_next;
      end
   end

   // one-cycle clear command; a written 0 issues nothing
   assign clear_next = wr_drive && reg_wdata_i[mdc_pkg::DRV_CLEAR_BIT];

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         clear_pulse_reg <= 1'b0;
      end else begin
         clear_pulse_reg <= clear_next;
      end
   end

   always_comb begin
      prot_next = prot_reg;
      if (wr_prot) begin
         prot_next = reg_wdata_i[6:0];
      end
   end

   // protection and reporting, bit 7 is not stored
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         prot_reg <= PRT_RST[6:0];
      end else begin
         prot_reg <= prot_next;
      end
   end

   // latched serial faults: a new event beats a clear in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         framing_flag_reg <= 1'b0;
      end else if (serial_clock_framing_event_i) begin
         framing_flag_reg <= 1'b1;
      end else if (clear_pulse_reg) begin
         framing_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         parity_flag_reg <= 1'b0;
      end else if (serial_parity_event_i) begin
         parity_flag_reg <= 1'b1;
      end else if (clear_pulse_reg) begin
         parity_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         address_flag_reg <= 1'b0;
      end else if (serial_address_event_i) begin
         address_flag_reg <= 1'b1;
      end else if (clear_pulse_reg) begin
         address_flag_reg <= 1'b0;
      end
   end

   // readback; unmapped offsets return zero
   always_comb begin
      rdata_next = 8'h00;
      if (reg_addr_i == A_LOCK) begin
         rdata_next = {5'h00, lock_field_reg};
      end else if (reg_addr_i == A_DRIVE) begin
         rdata_next = {drive_rsvd_reg, sdo_push_pull_reg, slew_reg,
            scheme_reg, 1'b0};
      end else if (reg_addr_i == A_PROT) begin
         rdata_next = {1'b0, prot_reg};
      end
   end

   // data is caught only on a read, so it holds until the next one
   always_comb begin
      reg_rdata_next = reg_rdata_o;
      if (reg_rd_i) begin
         reg_rdata_next = rdata_next;
      end
   end

   assign reg_rvalid_next = reg_rd_i;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= reg_rdata_next;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rvalid_next;
      end
   end

   // power stage levels cross from outside the clock domain
   mdc_sync3 #(
      .WIDTH(2),
      .RESET_VAL(2'h0)
   ) u_pin_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .async_i({overtemp_warning_i, driver_fault_i}),
      .level_o(pin_level)
   );

   // fault pin sources and their reporting controls
   logic serial_fault_any;
   logic serial_report_off;
   logic overtemp_report_on;
   assign serial_fault_any = framing_flag_reg | parity_flag_reg |
      address_flag_reg;
   assign serial_report_off = prot_reg[mdc_pkg::PRT_SER_OFF_BIT];
   assign overtemp_report_on = prot_reg[mdc_pkg::PRT_OTW_ON_BIT];

   mdc_fault_report u_fault_report (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .driver_fault_i(pin_level[0]),
      .overtemp_warning_i(pin_level[1]),
      .serial_fault_any_i(serial_fault_any),
      .serial_fault_report_off_i(serial_report_off),
      .overtemp_warning_report_on_i(overtemp_report_on),
      .fault_indicator_pin_o(fault_indicator_pin_o),
      .fault_indicator_pin_oe_o(fault_indicator_pin_oe_o)
   );

   // configuration outputs straight from their flip-flops
   assign serial_out_drive_select_o = sdo_push_pull_reg;
   assign slew_select_o = slew_reg;
   assign input_scheme_o = scheme_reg;
   assign full_duty_rate_40k_o = prot_reg[mdc_pkg::PRT_DUTY_RATE_BIT];
   assign overvoltage_threshold_select_o =
      prot_reg[mdc_pkg::PRT_OV_SEL_BIT];
   assign overvoltage_protect_on_o = prot_reg[mdc_pkg::PRT_OV_ON_BIT];
   assign registers_locked_o = locked_reg;
   assign latched_fault_clear_o = clear_pulse_reg;
   assign serial_clock_framing_flag_o = framing_flag_reg;
   assign serial_parity_flag_o = parity_flag_reg;
   assign serial_address_flag_o = address_flag_reg;
endmodule // mdc_control_regs

// ===== sim/mdc_control_regs_assertions.sv
// Purpose: port-level checks of the control register bank
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto the design from the bench top
`timescale 1ns/1ns
module mdc_control_regs_assertions #(
   parameter int ADDR_W = 6
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   // fault event and flag
   input wire logic serial_parity_event_i,
   input wire logic serial_parity_flag_o,
   // configuration
   input wire logic serial_out_drive_select_o,
   input wire logic [1:0] slew_select_o,
   input wire logic [1:0] input_scheme_o,
   input wire logic full_duty_rate_40k_o,
   input wire logic overvoltage_threshold_select_o,
   input wire logic overvoltage_protect_on_o,
   input wire logic registers_locked_o,
   input wire logic latched_fault_clear_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   logic wr_lck, wr_drv, wr_prt, key_lck, key_opn, clr_req;
   logic [5:0] cfg;
   assign wr_lck = reg_wr_i && reg_addr_i == mdc_pkg::OFS_CONTROL_LOCK;
   assign wr_drv = reg_wr_i && reg_addr_i == mdc_pkg::OFS_DRIVE_CONFIGURATION;
   assign wr_prt = reg_wr_i && reg_addr_i == mdc_pkg::OFS_PROTECTION_REPORTING;
   assign key_lck = reg_wdata_i[2:0] == mdc_pkg::LOCK_KEY_LOCK;
   assign key_opn = reg_wdata_i[2:0] == mdc_pkg::LOCK_KEY_UNLOCK;
   assign clr_req = wr_drv && reg_wdata_i[0] && !registers_locked_o;
   assign cfg = {serial_out_drive_select_o, slew_select_o, input_scheme_o,
      full_duty_rate_40k_o};

   sequence s_clear_wr;
      clr_req;
   endsequence
   sequence s_quiet;
      !reg_wr_i && !serial_parity_event_i;
   endsequence

   AST_LOCK_SET: assert property (
      wr_lck && key_lck |=> registers_locked_o)
      else $error("lock key did not lock");
   AST_UNLOCK: assert property (
      wr_lck && key_opn |=> !registers_locked_o)
      else $error("unlock key did not unlock");
   AST_LOCK_HOLD: assert property (
      !(wr_lck && (key_lck || key_opn)) |=>
      registers_locked_o == $past(registers_locked_o))
      else $error("lock state moved without a key");
   AST_LOCK_DROP: assert property (
      (wr_drv || wr_prt) && registers_locked_o |=>
      $stable(cfg) && !latched_fault_clear_o)
      else $error("locked write took effect");
   AST_DRV_WR: assert property (
      wr_drv && !registers_locked_o |=>
      cfg[5:1] == $past(reg_wdata_i[5:1]))
      else $error("drive fields not loaded");
   AST_PRT_WR: assert property (
      wr_prt && !registers_locked_o |=>
      {full_duty_rate_40k_o, overvoltage_threshold_select_o,
      overvoltage_protect_on_o} == $past(reg_wdata_i[4:2]))
      else $error("protection fields not loaded");
   AST_CLEAR: assert property (
      s_clear_wr ##1 s_quiet |-> latched_fault_clear_o
      ##1 (!latched_fault_clear_o && !serial_parity_flag_o))
      else $error("clear pulse or flag clear wrong");
   AST_CLEAR_CAUSE: assert property (
      latched_fault_clear_o |-> $past(clr_req))
      else $error("clear pulse without a clear write");
   AST_RVALID: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read not answered");
   AST_RSVD_RD: assert property (
      reg_rd_i && reg_addr_i == mdc_pkg::OFS_PROTECTION_REPORTING |=>
      !reg_rdata_o[7])
      else $error("reserved bit read as one");
   AST_FLAG_SET: assert property (
      serial_parity_event_i |=> serial_parity_flag_o)
      else $error("parity flag not set");
endmodule // mdc_control_regs_assertions

// ===== sim/mdc_host_model.sv
// Purpose: serial host stand-in issuing decoded register accesses
// Assumes: one strobe per atomic write, read answered by rvalid
// Notes: GAP adds idle cycles to act as a slow host
`timescale 1ns/1ns
module mdc_host_model #(
   parameter int GAP = 0
) (
   // clock
   input wire logic clk_sys_i,
   // register port
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [5:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 6'h2A;
      reg_wdata_o = 8'h5A;
   end
   // whole word in one strobe; keys only reach the lock field this way
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      repeat (GAP) @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge clk_sys_i);
      reg_wr_o <= 1'b0;
      // released lines show junk, not the last value
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] q,
      output logic ok);
      ok = 1'b0;
      q = 8'h00;
      repeat (GAP) @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge clk_sys_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge clk_sys_i);
         ok = reg_rvalid_i === 1'b1;
         q = reg_rdata_i;
      end
   endtask
endmodule // mdc_host_model

// ===== sim/tb.sv
// Purpose: self-checking bench for the control register bank
// Assumes: host model drives the register port
// Notes: fault pin level is worked out with a pull-up
`timescale 1ns/1ns
module tb;
   logic clk_sys_i, reset_i, wr, rd, rv, ok, drv_flt, otw;
   logic sdo, ovsel, ovp, rate, locked, clr, pin, oe;
   logic [5:0] addr;
   logic [7:0] wd, rdata, q;
   logic [2:0] ev;
   logic [1:0] slew, scheme;
   wire [2:0] fl;
   wire pin_lvl = oe ? pin : 1'b1;
   int num_errors = 0;
   int cmp_count = 0;

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   mdc_host_model #(.GAP(0)) host (.clk_sys_i(clk_sys_i), .reg_wr_o(wr),
      .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wd),
      .reg_rdata_i(rdata), .reg_rvalid_i(rv));
   mdc_control_regs #(.ADDR_W(6)) uut (.clk_sys_i(clk_sys_i),
      .reset_i(reset_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_rvalid_o(rv),
      .serial_clock_framing_event_i(ev[0]), .serial_parity_event_i(ev[1]),
      .serial_address_event_i(ev[2]), .driver_fault_i(drv_flt),
      .overtemp_warning_i(otw), .serial_out_drive_select_o(sdo),
      .slew_select_o(slew), .input_scheme_o(scheme),
      .full_duty_rate_40k_o(rate), .overvoltage_threshold_select_o(ovsel),
      .overvoltage_protect_on_o(ovp), .registers_locked_o(locked),
      .latched_fault_clear_o(clr), .serial_clock_framing_flag_o(fl[0]),
      .serial_parity_flag_o(fl[1]), .serial_address_flag_o(fl[2]),
      .fault_indicator_pin_o(pin), .fault_indicator_pin_oe_o(oe));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
      host.rd(a, q, ok);
      chk({7'h00, ok}, 8'h01);
      chk(q, exp);
   endtask
   task automatic pulse(input logic [2:0] v);
      @(posedge clk_sys_i);
      ev <= v;
      @(posedge clk_sys_i);
      ev <= 3'h0;
      #1;
   endtask
   // synchroniser delay lets the pin trail its cause by a few cycles
   task automatic pin_is(input logic exp);
      for (int i = 0; i < 10 && pin_lvl !== exp; i++) @(posedge clk_sys_i);
      #1 chk({7'h00, pin_lvl}, {7'h00, exp});
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      logic [7:0] d;
      reset_i = 1'b1;
      ev = 3'h0;
      drv_flt = 1'b0;
      otw = 1'b0;
      repeat (8) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      rchk(6'h03, 8'h00);
      rchk(6'h04, 8'h60);
      rchk(6'h05, 8'h46);
      rchk(6'h07, 8'h00);
      chk({4'h0, sdo, ovp, locked, oe}, 8'h0C);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         d = {i[0] ? 2'b10 : 2'b01, ~i[0], i[3:0], 1'b0};
         host.wr(6'h04, d);
         #1 chk({2'h0, sdo, slew, scheme, 1'b0}, {2'h0, d[5:0]});
         rchk(6'h04, d);
      end
      host.wr(6'h05, 8'hFF);
      #1 chk({5'h0, rate, ovsel, ovp}, 8'h07);
      rchk(6'h05, 8'h7F);
      host.wr(6'h05, 8'h00);
      #1 chk({5'h0, rate, ovsel, ovp}, 8'h00);
      $display("test fields done");
      pulse(3'h7);
      chk({5'h0, fl}, 8'h07);
      host.wr(6'h04, 8'h61);
      #1 chk({7'h0, clr}, 8'h01);
      @(posedge clk_sys_i);
      #1 chk({4'h0, clr, fl}, 8'h00);
      rchk(6'h04, 8'h60);
      pulse(3'h2);
      host.wr(6'h04, 8'h60);
      @(posedge clk_sys_i);
      #1 chk({4'h0, clr, fl}, 8'h02);
      $display("test clear done");
      pin_is(1'b0);
      host.wr(6'h05, 8'h02);
      pin_is(1'b1);
      otw <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      #1 chk({7'h0, pin_lvl}, 8'h01);
      host.wr(6'h05, 8'h03);
      pin_is(1'b0);
      otw <= 1'b0;
      host.wr(6'h05, 8'h02);
      pin_is(1'b1);
      drv_flt <= 1'b1;
      pin_is(1'b0);
      drv_flt <= 1'b0;
      host.wr(6'h04, 8'h61);
      $display("test pin done");
      host.wr(6'h03, 8'hFE);
      #1 chk({7'h0, locked}, 8'h01);
      rchk(6'h03, 8'h06);
      host.wr(6'h04, 8'h01);
      #1 chk({4'h0, clr, fl}, 8'h00);
      host.wr(6'h05, 8'h47);
      rchk(6'h04, 8'h60);
      rchk(6'h05, 8'h02);
      host.wr(6'h03, 8'h05);
      #1 chk({7'h0, locked}, 8'h01);
      host.wr(6'h03, 8'h03);
      #1 chk({7'h0, locked}, 8'h00);
      host.wr(6'h03, 8'h07);
      #1 chk({7'h0, locked}, 8'h00);
      host.wr(6'h04, 8'h28);
      rchk(6'h04, 8'h28);
      host.wr(6'h03, 8'h06);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      #1 chk({7'h0, locked}, 8'h00);
      rchk(6'h04, 8'h60);
      $display("test lock done");
      results();
   end
endmodule // tb

bind mdc_control_regs mdc_control_regs_assertions #(.ADDR_W(ADDR_W)) u_chk (
   .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
   .serial_parity_event_i(serial_parity_event_i),
   .serial_parity_flag_o(serial_parity_flag_o),
   .serial_out_drive_select_o(serial_out_drive_select_o),
   .slew_select_o(slew_select_o), .input_scheme_o(input_scheme_o),
   .full_duty_rate_40k_o(full_duty_rate_40k_o),
   .overvoltage_threshold_select_o(overvoltage_threshold_select_o),
   .overvoltage_protect_on_o(overvoltage_protect_on_o),
   .registers_locked_o(registers_locked_o),
   .latched_fault_clear_o(latched_fault_clear_o));
